//--- bench/mlic_core_model.sv
// processor core stand-in: takes offered vectors after a set latency
`timescale 1ns/1ps
module mlic_core_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       pc_load,
  input  wire logic [3:0] lat,
  output logic            core_ack
);
  logic [3:0] cnt_q;
  // one ack per offer; the offer falls at the edge that samples the ack,
  // so a fresh offer right behind it starts a fresh count
  always @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_ack <= 1'b0;
      cnt_q    <= 4'h0;
    end else if (core_ack) begin
      core_ack <= 1'b0;
      cnt_q    <= 4'h0;
    end else if (!pc_load) begin
      cnt_q <= 4'h0;
    end else if (cnt_q >= lat) begin
      core_ack <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : mlic_core_model

//--- bench/tb_top.sv
// self-checking bench for the multi-level interrupt controller
`timescale 1ns/1ps
module tb_top;
  import mlic_pkg::*;
  localparam int N = 8;
  logic            clk = 0, rst_n = 0, crystal_fail = 0, core_reti = 0, vec_in_boot = 0;
  logic            lo_en = 1, med_en = 1, hi_en = 1, pc_load, ack_nmi, core_ack;
  logic [N-1:0]    irq_req = '0, lvl_enable_low = '1;
  logic [2*N-1:0]  irq_level = '0;
  logic [16*N-1:0] irq_base = '0, irq_offset = '0;
  mlic_arb_e       low_arb_mode = MLIC_ARB_FIXED;
  mlic_addr_t      boot_start = '0, pc_vector;
  logic [2:0]      ack_idx;
  logic [3:0]      in_service, lat = 4'h0;
  int              n_mismatch = 0, samples_checked = 0, cycles = 0;
  mlic_ctrl #(.N(N)) dut (.clk, .rst_n, .irq_req, .irq_level, .irq_base, .irq_offset,
    .crystal_fail, .lvl_enable_low, .lo_en, .med_en, .hi_en, .low_arb_mode, .vec_in_boot,
    .boot_start, .core_ack, .core_reti, .pc_load, .pc_vector, .ack_idx, .ack_nmi, .in_service);
  mlic_core_model core (.clk, .rst_n, .pc_load, .lat, .core_ack);
  always #5 clk = ~clk;
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic results();
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // expected vector: base plus offset, nmi fixed, all moved by boot start
  function automatic mlic_addr_t vec_of(input int i);
    mlic_addr_t b;
    b = vec_in_boot ? boot_start : 16'h0000;
    if (i < 0)
      return 16'h0002 + b;
    return irq_base[16*i +: 16] + irq_offset[16*i +: 16] + b;
  endfunction : vec_of
  task automatic raise(input int i, input logic [1:0] lv);
    irq_level[2*i +: 2] = lv;
    irq_req[i] = 1'b1;
  endtask : raise
  // wait for the offer, compare it, drop the request, then check levels
  task automatic serve(input int i, input logic [3:0] ins);
    int k;
    k = 0;
    while (pc_load !== 1'b1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    check({15'h0, pc_load}, 16'h0001);
    check(pc_vector, vec_of(i));
    check({15'h0, ack_nmi}, {15'h0, i < 0});
    if (i >= 0)
      check({13'h0, ack_idx}, i[15:0]);
    if (i < 0)
      crystal_fail = 1'b0;
    else
      irq_req[i] = 1'b0;
    k = 0;
    while (pc_load !== 1'b0 && k < 60) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    check({12'h0, in_service}, {12'h0, ins});
  endtask : serve
  task automatic reti(input logic [3:0] ins);
    core_reti = 1'b1;
    @(negedge clk);
    core_reti = 1'b0;
    @(negedge clk);
    check({12'h0, in_service}, {12'h0, ins});
  endtask : reti
  initial begin
    void'($urandom(32'h5e16));
    // distinct bases so no two sources can share a vector
    for (int i = 3; i < N; i++) begin
      irq_base[16*i +: 16] = 16'h0080 + 16'(16 * i);
      irq_offset[16*i +: 16] = 16'($urandom_range(0, 15));
    end
    irq_base[15:0] = 16'h000c;
    irq_offset[15:0] = 16'($urandom_range(0, 7));
    irq_base[31:16] = 16'h0040;
    irq_offset[31:16] = 16'($urandom_range(0, 3));
    irq_base[47:32] = 16'h0030;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    // nesting low, medium, high, nmi, with and without boot relocation
    for (int b = 0; b < 2; b++) begin
      vec_in_boot = b[0];
      boot_start = 16'($urandom) & 16'hff00;
      lat = 4'($urandom_range(0, 5));
      raise(3, 2'h1);
      serve(3, 4'h1);
      raise(4, 2'h1);
      repeat (6) @(negedge clk);
      check({15'h0, pc_load}, 16'h0000);
      raise(1, 2'h2);
      serve(1, 4'h3);
      raise(2, 2'h3);
      serve(2, 4'h7);
      crystal_fail = 1'b1;
      serve(-1, 4'hf);
      reti(4'h7);
      reti(4'h3);
      reti(4'h1);
      reti(4'h0);
      serve(4, 4'h1);
      reti(4'h0);
    end
    // fixed repeats the lowest index, round-robin moves on
    for (int m = 0; m < 2; m++) begin
      low_arb_mode = mlic_arb_e'(m);
      raise(5, 2'h1);
      raise(6, 2'h1);
      serve(5, 4'h1);
      raise(5, 2'h1);
      reti(4'h0);
      serve(m ? 6 : 5, 4'h1);
      reti(4'h0);
      serve(m ? 5 : 6, 4'h1);
      reti(4'h0);
    end
    // masked low source, disabled high level and level 0 stay silent
    lvl_enable_low[7] = 1'b0;
    raise(7, 2'h1);
    hi_en = 1'b0;
    raise(6, 2'h3);
    raise(5, 2'h0);
    repeat (8) @(negedge clk);
    check({15'h0, pc_load}, 16'h0000);
    irq_req[5] = 1'b0;
    hi_en = 1'b1;
    serve(6, 4'h4);
    reti(4'h0);
    lvl_enable_low[7] = 1'b1;
    serve(7, 4'h1);
    reti(4'h0);
    results();
  end
endmodule : tb_top

//--- rtl/mlic_cfg.svh
// constants for the multi-level interrupt controller
// How it works
// - each source carries a two-bit level: high, medium or low
// - medium request preempts a running low-level routine
// - high request preempts running low and medium routines
// - low-level arbitration is fixed or rotating round-robin, selectable
// - crystal failure raises non-maskable interrupt at word 0x002
// - accepted interrupt loads core program counter with its vector
// - vector equals peripheral base plus interrupt offset
// - all vectors are program word addresses
// - single-interrupt peripheral uses direct vector, serial port C at 0x030
// - dma group base is word 0x00c
// - nonvolatile memory group base is word 0x040
// - whole vector table can move to start of boot section
// - every source owns a distinct vector; not enforced here, two sources whose base plus offset match share one vector
`ifndef MLIC_CFG_SVH
`define MLIC_CFG_SVH
`define MLIC_RESET_VEC          16'h0000
`define MLIC_CRYSTAL_FAIL_VEC   16'h0002
`define MLIC_DMA_BASE           16'h000c
`define MLIC_SERIAL_C_VEC       16'h0030
`define MLIC_NVM_BASE           16'h0040
`define MLIC_LVL_LOW            2'h1
`define MLIC_LVL_MED            2'h2
`define MLIC_LVL_HIGH           2'h3
`define MLIC_INSVC_NMI          2'h3
`endif

//--- rtl/mlic_ctrl.sv
// multi-level interrupt controller top: levels, preemption, vectors
`timescale 1ns/1ps
`include "mlic_cfg.svh"
module mlic_ctrl #(
  parameter int N = 8
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [N-1:0]         irq_req,
  input  wire logic [2*N-1:0]       irq_level,
  input  wire logic [16*N-1:0]      irq_base,
  input  wire logic [16*N-1:0]      irq_offset,
  input  wire logic                 crystal_fail,
  input  wire logic [N-1:0]         lvl_enable_low,
  input  wire logic                 lo_en,
  input  wire logic                 med_en,
  input  wire logic                 hi_en,
  input  wire mlic_pkg::mlic_arb_e  low_arb_mode,
  input  wire logic                 vec_in_boot,
  input  wire mlic_pkg::mlic_addr_t boot_start,
  input  wire logic                 core_ack,
  input  wire logic                 core_reti,
  output logic                      pc_load,
  output mlic_pkg::mlic_addr_t      pc_vector,
  output logic [$clog2(N)-1:0]      ack_idx,
  output logic                      ack_nmi,
  output logic [3:0]                in_service
);
  import mlic_pkg::*;
  localparam int W = $clog2(N);

  // level field of source k
  function automatic mlic_lvl_t lvl_of(input logic [2*N-1:0] l, input int k);
    return l[2*k +: 2];
  endfunction : lvl_of

  logic [N-1:0] hi_req, med_req, lo_req;
  always_comb begin
    for (int k = 0; k < N; k++) begin
      hi_req[k]  = irq_req[k] && hi_en  && lvl_of(irq_level, k) == `MLIC_LVL_HIGH;
      med_req[k] = irq_req[k] && med_en && lvl_of(irq_level, k) == `MLIC_LVL_MED;
      lo_req[k]  = irq_req[k] && lo_en  && lvl_of(irq_level, k) == `MLIC_LVL_LOW
                   && lvl_enable_low[k];
    end
  end

  // fixed lowest-index pick for high and medium
  function automatic logic [W-1:0] lowest(input logic [N-1:0] r);
    logic [W-1:0] res;
    res = '0;
    for (int i = N - 1; i >= 0; i--) if (r[i]) res = W'(i);
    return res;
  endfunction : lowest

  // in-service bits: 0 low, 1 med, 2 high, 3 nmi
  logic [3:0]   insvc_q;
  logic [3:0]   insvc_d;
  logic [1:0]   ack_lvl_q;
  logic         pend_q;
  logic         nmi_pend_q;
  logic         lo_any;
  logic [W-1:0] lo_idx;
  logic         take;

  // crystal failure comes from the oscillator monitor, not from this clock
  logic         fail_s1_q;
  logic         fail_s2_q;
  logic         fail_s3_q;
  logic         fail_flt_q;

  // three stages; a change counts only once the last two agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_s1_q <= 1'b0;
      fail_s2_q <= 1'b0;
      fail_s3_q <= 1'b0;
    end else begin
      fail_s1_q <= crystal_fail;
      fail_s2_q <= fail_s1_q;
      fail_s3_q <= fail_s2_q;
    end
  end

  // filtered level follows the pin only when the last two stages agree
  wire logic fail_agree = (fail_s2_q == fail_s3_q);
  wire logic fail_flt_d = fail_agree ? fail_s3_q : fail_flt_q;
  // one nmi per failure event, however long the pin stays high
  wire logic fail_rise  = fail_flt_d && !fail_flt_q;

  // filtered level resets low like the idle pin, so reset makes no false edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) fail_flt_q <= 1'b0;
    else        fail_flt_q <= fail_flt_d;
  end

  // a level wins only if nothing equal or higher is in service
  wire logic       nmi_ok = nmi_pend_q && !insvc_q[3];
  wire logic       hi_ok  = |hi_req  && insvc_q[3:2] == 2'b00;
  wire logic       med_ok = |med_req && insvc_q[3:1] == 3'b000;
  wire logic       lo_ok  = lo_any   && insvc_q == 4'b0000;
  wire logic       sel_nmi = nmi_ok;
  wire logic [1:0] sel_lvl = hi_ok ? 2'd2 : med_ok ? 2'd1 : 2'd0;
  wire logic       sel_any = nmi_ok || hi_ok || med_ok || lo_ok;
  wire logic [W-1:0] sel_idx = hi_ok ? lowest(hi_req) : med_ok ? lowest(med_req) : lo_idx;
  assign take = sel_any && !pend_q;

  // pointer follows low requests as soon as they are offered, before the core's ack
  wire logic       lo_taken = take && sel_lvl == 2'd0 && !sel_nmi;

  mlic_low_arb #(.N(N)) u_low (
    .clk        (clk),
    .rst_n      (rst_n),
    .req        (lo_req),
    .mode       (low_arb_mode),
    .grant_taken(lo_taken),
    .taken_idx  (lo_idx),
    .any        (lo_any),
    .idx        (lo_idx)
  );

  // vector is base plus offset, in words
  wire mlic_addr_t sel_base = irq_base[16*sel_idx +: 16];
  wire mlic_addr_t sel_off  = irq_offset[16*sel_idx +: 16];
  // carry out of the word address space is dropped on purpose
  wire mlic_addr_t src_vec  = mlic_addr_t'(sel_base + sel_off);
  wire mlic_addr_t raw_vec = sel_nmi ? `MLIC_CRYSTAL_FAIL_VEC : src_vec;
  // table moved to boot section start
  wire mlic_addr_t fin_vec = vec_in_boot ? mlic_addr_t'(boot_start + raw_vec) : raw_vec;

  // top active level cleared on return, set on acceptance
  always_comb begin
    insvc_d = insvc_q;
    if (core_reti) begin
      if (insvc_q[3])      insvc_d[3] = 1'b0;
      else if (insvc_q[2]) insvc_d[2] = 1'b0;
      else if (insvc_q[1]) insvc_d[1] = 1'b0;
      else                 insvc_d[0] = 1'b0;
    end
    // acceptance is applied after the return, so a same-cycle set wins
    if (pend_q && core_ack) insvc_d[ack_nmi ? `MLIC_INSVC_NMI : ack_lvl_q] = 1'b1;
  end

  // nmi latch: failure event wins over the clear when the nmi is offered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) nmi_pend_q <= 1'b0;
    else        nmi_pend_q <= fail_rise || (nmi_pend_q && !(take && sel_nmi));
  end

  // present vector and hold until the core takes it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q    <= 1'b0;
      pc_load   <= 1'b0;
      pc_vector <= `MLIC_RESET_VEC;
      ack_idx   <= '0;
      ack_nmi   <= 1'b0;
      ack_lvl_q <= 2'd0;
    end else if (take) begin
      pend_q    <= 1'b1;
      pc_load   <= 1'b1;
      pc_vector <= fin_vec;
      ack_idx   <= sel_idx;
      ack_nmi   <= sel_nmi;
      ack_lvl_q <= sel_lvl;
    end else if (core_ack) begin
      // the offer drops at the edge that samples the core's ack
      pend_q    <= 1'b0;
      pc_load   <= 1'b0;
    end
  end

  // status mirrors in-service state; a copy keeps the output a plain flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      insvc_q    <= 4'h0;
      in_service <= 4'h0;
    end else begin
      insvc_q    <= insvc_d;
      in_service <= insvc_d;
    end
  end

  a_nmi_vector: assert property (@(posedge clk) disable iff (!rst_n)
    take && sel_nmi && !vec_in_boot |=> pc_vector == `MLIC_CRYSTAL_FAIL_VEC)
    else $error("nmi vector wrong");
  a_nmi_latched: assert property (@(posedge clk) disable iff (!rst_n)
    fail_rise |=> nmi_pend_q)
    else $error("crystal failure lost");
  a_pc_held: assert property (@(posedge clk) disable iff (!rst_n)
    pc_load && !core_ack |=> pc_load && $stable(pc_vector))
    else $error("vector dropped before ack");
  a_vec_sum: assert property (@(posedge clk) disable iff (!rst_n)
    take && !sel_nmi && !vec_in_boot |=> pc_vector == $past(src_vec))
    else $error("vector not base plus offset");
  a_direct_vec: assert property (@(posedge clk) disable iff (!rst_n)
    take && !sel_nmi && !vec_in_boot && sel_base == `MLIC_SERIAL_C_VEC
    |=> pc_vector == `MLIC_SERIAL_C_VEC)
    else $error("direct vector moved");
  a_group_base: assert property (@(posedge clk) disable iff (!rst_n)
    take && !sel_nmi && !vec_in_boot
    && (sel_base == `MLIC_DMA_BASE || sel_base == `MLIC_NVM_BASE)
    |=> pc_vector >= $past(sel_base))
    else $error("group vector below its base");
  a_boot_move: assert property (@(posedge clk) disable iff (!rst_n)
    take && vec_in_boot |=> pc_vector == $past(boot_start) + $past(raw_vec))
    else $error("boot relocation wrong");
  a_no_low_preempt: assert property (@(posedge clk) disable iff (!rst_n)
    take && insvc_q[1] |-> sel_lvl == 2'd2 || sel_nmi)
    else $error("low or med preempted medium");
  a_high_blocks: assert property (@(posedge clk) disable iff (!rst_n)
    insvc_q[2] && !sel_nmi |-> !take)
    else $error("preempted high routine");
  a_insvc_set: assert property (@(posedge clk) disable iff (!rst_n)
    pend_q && core_ack && !ack_nmi && !core_reti |=> insvc_q[$past(ack_lvl_q)])
    else $error("in-service not set");
  a_level_pick: assert property (@(posedge clk) disable iff (!rst_n)
    take && !sel_nmi && sel_lvl == 2'd0 |-> lvl_of(irq_level, sel_idx) == `MLIC_LVL_LOW)
    else $error("wrong level picked");
  // main scenarios: nmi, nesting, rotation, relocation
  c_nmi: cover property (@(posedge clk) disable iff (!rst_n) take && sel_nmi);
  c_high_nest: cover property (@(posedge clk) disable iff (!rst_n) take && hi_ok && insvc_q[1]);
  c_boot: cover property (@(posedge clk) disable iff (!rst_n) take && vec_in_boot);
  c_preempt: cover property (@(posedge clk) disable iff (!rst_n) take && insvc_q[0]);
  c_rr: cover property (@(posedge clk) disable iff (!rst_n)
    take && low_arb_mode == MLIC_ARB_RROBIN && sel_lvl == 2'd0);
endmodule : mlic_ctrl

//--- rtl/mlic_low_arb.sv
// low-level arbiter: fixed or round-robin among low requests
`timescale 1ns/1ps
`include "mlic_cfg.svh"
module mlic_low_arb #(
  parameter int N = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [N-1:0]     req,
  input  wire mlic_pkg::mlic_arb_e mode,
  input  wire logic             grant_taken,
  input  wire logic [$clog2(N)-1:0] taken_idx,
  output logic                  any,
  output logic [$clog2(N)-1:0]  idx
);
  import mlic_pkg::*;
  localparam int W = $clog2(N);

  // rotating pointer: lowest index after last served wins
  logic [W-1:0] last_q;
  logic [W-1:0] last_d;

  // finds first request at or after a start index
  function automatic logic [W-1:0] first_from(input logic [N-1:0] r,
                                                input logic [W-1:0] start);
    logic [W-1:0] k;
    logic [W-1:0] res;
    res = start;
    for (int i = N - 1; i >= 0; i--) begin
      k = W'((int'(start) + i) % N);
      if (r[k]) res = k;
    end
    return res;
  endfunction : first_from

  wire logic [W-1:0] start_w = (mode == MLIC_ARB_RROBIN) ? W'((int'(last_q) + 1) % N) : '0;
  assign any = |req;
  assign idx = first_from(req, start_w);
  assign last_d = grant_taken ? taken_idx : last_q;

  // pointer only moves when a low request is offered, so starved sources rise in turn
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) last_q <= W'(N - 1);
    else        last_q <= last_d;
  end
endmodule : mlic_low_arb

//--- rtl/mlic_pkg.sv
// types for the multi-level interrupt controller
package mlic_pkg;
  typedef logic [1:0]  mlic_lvl_t;
  typedef logic [15:0] mlic_addr_t;
  typedef enum logic {MLIC_ARB_FIXED, MLIC_ARB_RROBIN} mlic_arb_e;
endpackage : mlic_pkg
